/* File: design/qdm_pkg.sv */
// constants shared by the quadrature modulator back end
// assumes a single 200 MHz system clock and byte-wide control writes
`default_nettype none

package qdm_pkg;
    // ********************************
    // control register byte addresses
    // ********************************
    localparam logic [7:0] QDM_ADDR_TW0  = 8'h16;  // tuning word bits 7:0
    localparam logic [7:0] QDM_ADDR_TW1  = 8'h17;  // tuning word bits 15:8
    localparam logic [7:0] QDM_ADDR_TW2  = 8'h18;  // tuning word bits 23:16
    localparam logic [7:0] QDM_ADDR_TW3  = 8'h19;  // tuning word bits 31:24
    localparam logic [7:0] QDM_ADDR_CTRL = 8'h1A;  // control byte
    localparam int         QDM_CTRL_INV  = 0;      // spectral inversion bit
    localparam int         QDM_CTRL_PEND = 1;      // tuning bytes pending (read only)

    // ********************************
    // widths and reset values
    // ********************************
    localparam int          QDM_TW_W     = 32;
    localparam int          QDM_SMP_W    = 10;
    localparam int          QDM_PROD_W   = 20;
    localparam int          QDM_SUM_W    = 21;
    localparam int          QDM_ACC_W    = 26;
    localparam int          QDM_DAC_W    = 10;
    localparam int          QDM_FIFO_D   = 4;
    localparam logic [31:0] QDM_TW_RST   = 32'h0000_0000;
    localparam logic [3:0]  QDM_ALL_BYTES = 4'hF;

    // ********************************
    // inverse sinc taps, y = (C*x1 - S*x0 - S*x2) >> SHIFT
    // ********************************
    localparam logic signed [25:0] QDM_FIR_CENTER = 26'sh0000012;
    localparam logic signed [25:0] QDM_FIR_SIDE   = 26'sh0000001;
    localparam int                 QDM_FIR_SHIFT  = 15;

    // ********************************
    // quarter wave sine table, half-step offset, amplitude 511
    // ********************************
    localparam logic [8:0] QDM_SINE_TAB [16] = '{
        9'h019, 9'h04B, 9'h07C, 9'h0AC, 9'h0DA, 9'h107, 9'h130, 9'h157,
        9'h17B, 9'h19A, 9'h1B6, 9'h1CE, 9'h1E1, 9'h1F0, 9'h1F9, 9'h1FE
    };
    localparam logic [5:0] QDM_QUARTER = 6'h10;
endpackage : qdm_pkg

`default_nettype wire

/* File: design/qdm_stream_if.sv */
// valid/ready word stream between the modulator's own modules
// assumes both ends on the same clock
`default_nettype none

interface qdm_stream_if #(parameter int WIDTH = 20);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : qdm_stream_if

`default_nettype wire

/* File: design/qdm_fifo.sv */
// small flip-flop FIFO with valid/ready on both sides
// assumes one clock; storage indexed by read and write pointers
`default_nettype none

module qdm_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // stream sides
    qdm_stream_if.snk wr,
    qdm_stream_if.src rd
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    // honest full and empty flags
    assign wr.ready = (count_q != FULL);
    assign rd.valid = (count_q != '0);
    assign rd.data  = mem[rdPtr_q];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_q] <= wr.data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + CW'(push) - CW'(pop);
        end
    end

    // fill level never exceeds depth, a push while full is refused
    property p_no_overflow;
        @(posedge clk) disable iff (!rst_n)
        (count_q == FULL && !pop) |=> (count_q == FULL);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count changed while full");
endmodule : qdm_fifo

`default_nettype wire

/* File: design/qdm_modulator.sv */
// quadrature modulator back end: carrier synthesizer, mixers, adder,
// inverse sinc filter and 10-bit converter word
// assumes samples, register writes and converter ready all on clk
//
// Functional notes
// - carrier frequency set by 32-bit tuning word loaded through control writes
// - 32-bit phase accumulator advances by the tuning word every clock
// - tuning word bytes live at control addresses 16h to 19h
// - I multiplies cosine carrier, Q multiplies sine carrier
// - products summed; without inversion the sum is I cos plus Q sin
// - inversion bit negates the Q product at the adder input
// - inversion reverses the rotation direction of the constellation
// - sum passes an inverse sinc filter flattening the band gain
// - filter output drives a 10-bit converter word each clock the converter is ready
// - I and Q multiplier inputs are 10 bits wide each
`default_nettype none

module qdm_modulator
    import qdm_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // control register port
    input  wire logic                 regWrite,
    input  wire logic [7:0]           regAddr,
    input  wire logic [7:0]           regWrData,
    output logic      [7:0]           regRdData,
    // baseband sample input
    input  wire logic                 sampleValid,
    input  wire logic [QDM_SMP_W-1:0] sampleI,
    input  wire logic [QDM_SMP_W-1:0] sampleQ,
    output logic                      sampleReady,
    // converter side
    input  wire logic                 dacReady,
    output logic      [QDM_DAC_W-1:0] dacWord,
    output logic                      dacValid
);
    // ****************************************
    // declarations
    // ****************************************
    qdm_stream_if #(.WIDTH(2 * QDM_SMP_W)) inStream ();
    qdm_stream_if #(.WIDTH(2 * QDM_SMP_W)) outStream ();

    logic [7:0]                twByte_q [4];
    logic [3:0]                twMask_q;
    logic [3:0]                twMask_d;
    logic [QDM_TW_W-1:0]       twActive_q;
    logic [QDM_TW_W-1:0]       twShadow;
    logic                      invert_q;
    logic [QDM_TW_W-1:0]       phase_q;
    logic                      adv;
    logic                      twComplete;
    logic [3:0]                byteHit;

    logic                      vA_q, vB_q, vC_q, vD_q;
    logic signed [QDM_SMP_W-1:0]  iA_q, qA_q, cosA_q, sinA_q;
    logic signed [QDM_PROD_W-1:0] prodI_q, prodQ_q;
    logic signed [QDM_SUM_W-1:0]  sum_q, tap1_q, tap2_q;
    logic signed [QDM_ACC_W-1:0]  acc_q;
    logic signed [QDM_ACC_W-1:0]  accNext;

    // ****************************************
    // functions
    // ****************************************
    // quarter wave lookup with mirror and sign by quadrant
    function automatic logic signed [QDM_SMP_W-1:0] sineOf(input logic [5:0] ph);
        logic [3:0] idx;
        logic [9:0] mag;
        idx = ph[4] ? ~ph[3:0] : ph[3:0];
        mag = {1'b0, QDM_SINE_TAB[idx]};
        return ph[5] ? -signed'(mag) : signed'(mag);
    endfunction : sineOf

    // clip the scaled filter output into the converter range
    function automatic logic [QDM_DAC_W-1:0] clip(input logic signed [QDM_ACC_W-1:0] v);
        logic signed [QDM_ACC_W-1:0] s;
        s = v >>> QDM_FIR_SHIFT;
        if (s > QDM_ACC_W'(signed'(10'sh1FF))) begin
            return 10'h1FF;
        end else if (s < QDM_ACC_W'(signed'(10'sh200))) begin
            return 10'h200;
        end
        return s[QDM_DAC_W-1:0];
    endfunction : clip

    // ****************************************
    // control registers
    // ****************************************
    // tuning byte decode
    generate
        for (genvar b = 0; b < 4; b++) begin : g_twByte
            assign byteHit[b] = regWrite && (regAddr == QDM_ADDR_TW0 + 8'(b));
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    twByte_q[b] <= QDM_TW_RST[8*b +: 8];
                end else if (byteHit[b]) begin
                    twByte_q[b] <= regWrData;
                end
            end
            assign twShadow[8*b +: 8] = twByte_q[b];
        end
    endgenerate

    always_comb begin
        twMask_d   = twMask_q | byteHit;
        twComplete = (twMask_d == QDM_ALL_BYTES);
        if (twComplete) begin
            twMask_d = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            twMask_q   <= '0;
            twActive_q <= QDM_TW_RST;
        end else begin
            twMask_q <= twMask_d;
            if (twComplete) begin
                twActive_q <= {byteHit[3] ? regWrData : twByte_q[3],
                               byteHit[2] ? regWrData : twByte_q[2],
                               byteHit[1] ? regWrData : twByte_q[1],
                               byteHit[0] ? regWrData : twByte_q[0]};
            end
        end
    end

    // control byte holding the inversion bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            invert_q <= 1'b0;
        end else if (regWrite && regAddr == QDM_ADDR_CTRL) begin
            invert_q <= regWrData[QDM_CTRL_INV];
        end
    end

    // registered read back, unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= '0;
        end else begin
            case (regAddr)
                QDM_ADDR_TW0:  regRdData <= twByte_q[0];
                QDM_ADDR_TW1:  regRdData <= twByte_q[1];
                QDM_ADDR_TW2:  regRdData <= twByte_q[2];
                QDM_ADDR_TW3:  regRdData <= twByte_q[3];
                QDM_ADDR_CTRL: regRdData <= 8'({(twMask_q != '0), invert_q});
                default:       regRdData <= '0;
            endcase
        end
    end

    // ****************************************
    // carrier synthesizer
    // ****************************************
    // phase advances every clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
        end else begin
            phase_q <= phase_q + twActive_q;
        end
    end

    // ****************************************
    // input buffer
    // ****************************************
    assign inStream.valid = sampleValid;
    assign inStream.data  = {sampleI, sampleQ};
    assign sampleReady    = inStream.ready;
    assign adv            = dacReady;
    assign outStream.ready = adv;

    qdm_fifo #(
        .WIDTH (2 * QDM_SMP_W),
        .DEPTH (QDM_FIFO_D)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .wr    (inStream),
        .rd    (outStream)
    );

    // ****************************************
    // datapath pipeline, advances while converter ready
    // ****************************************
    // 10-bit samples with carrier pair
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vA_q   <= 1'b0;
            iA_q   <= '0;
            qA_q   <= '0;
            cosA_q <= '0;
            sinA_q <= '0;
        end else if (adv) begin
            vA_q   <= outStream.valid;
            iA_q   <= outStream.valid ? outStream.data[2*QDM_SMP_W-1 -: QDM_SMP_W] : '0;
            qA_q   <= outStream.valid ? outStream.data[QDM_SMP_W-1:0] : '0;
            cosA_q <= sineOf(phase_q[QDM_TW_W-1 -: 6] + QDM_QUARTER);
            sinA_q <= sineOf(phase_q[QDM_TW_W-1 -: 6]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vB_q    <= 1'b0;
            prodI_q <= '0;
            prodQ_q <= '0;
        end else if (adv) begin
            vB_q    <= vA_q;
            prodI_q <= iA_q * cosA_q;
            prodQ_q <= qA_q * sinA_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vC_q  <= 1'b0;
            sum_q <= '0;
        end else if (adv) begin
            vC_q  <= vB_q;
            sum_q <= invert_q ? QDM_SUM_W'(prodI_q) - QDM_SUM_W'(prodQ_q)
                              : QDM_SUM_W'(prodI_q) + QDM_SUM_W'(prodQ_q);
        end
    end

    assign accNext = QDM_FIR_CENTER * QDM_ACC_W'(tap1_q)
                   - QDM_FIR_SIDE * QDM_ACC_W'(sum_q)
                   - QDM_FIR_SIDE * QDM_ACC_W'(tap2_q);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vD_q   <= 1'b0;
            tap1_q <= '0;
            tap2_q <= '0;
            acc_q  <= '0;
        end else if (adv) begin
            vD_q   <= vC_q;
            tap1_q <= sum_q;
            tap2_q <= tap1_q;
            acc_q  <= accNext;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dacWord  <= '0;
            dacValid <= 1'b0;
        end else if (adv) begin
            dacWord  <= clip(acc_q);
            dacValid <= vD_q;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_lastByte;
        regWrite && (twMask_q | byteHit) == QDM_ALL_BYTES;
    endsequence

    sequence s_fiveAdv;
        adv [*5];
    endsequence

    property p_phaseStep;
        @(posedge clk) disable iff (!rst_n)
        ##1 (phase_q == $past(phase_q) + $past(twActive_q));
    endproperty
    a_phaseStep: assert property (p_phaseStep) else $error("phase step is not the tuning word");

    property p_twHold;
        @(posedge clk) disable iff (!rst_n)
        !twComplete |=> $stable(twActive_q);
    endproperty
    a_twHold: assert property (p_twHold) else $error("tuning word changed before all bytes");

    property p_twLoad;
        @(posedge clk) disable iff (!rst_n)
        s_lastByte ##1 1'b1 |-> (twActive_q == twShadow) && (twMask_q == '0);
    endproperty
    a_twLoad: assert property (p_twLoad) else $error("tuning word not loaded from bytes");

    property p_readBack;
        @(posedge clk) disable iff (!rst_n)
        (regAddr == QDM_ADDR_TW3) && !byteHit[3] |=> (regRdData == twByte_q[3]);
    endproperty
    a_readBack: assert property (p_readBack) else $error("tuning byte read back wrong");

    property p_mixer;
        @(posedge clk) disable iff (!rst_n)
        adv |=> (prodI_q == $past(iA_q) * $past(cosA_q)) && (prodQ_q == $past(qA_q) * $past(sinA_q));
    endproperty
    a_mixer: assert property (p_mixer) else $error("mixer product mismatch");

    property p_sumPlain;
        @(posedge clk) disable iff (!rst_n)
        adv && !invert_q |=> (sum_q == QDM_SUM_W'($past(prodI_q)) + QDM_SUM_W'($past(prodQ_q)));
    endproperty
    a_sumPlain: assert property (p_sumPlain) else $error("sum without inversion wrong");

    property p_sumInv;
        @(posedge clk) disable iff (!rst_n)
        adv && invert_q |=> (sum_q == QDM_SUM_W'($past(prodI_q)) - QDM_SUM_W'($past(prodQ_q)));
    endproperty
    a_sumInv: assert property (p_sumInv) else $error("inverted sum wrong");

    property p_latency;
        @(posedge clk) disable iff (!rst_n)
        (adv && outStream.valid) ##0 s_fiveAdv |=> dacValid;
    endproperty
    a_latency: assert property (p_latency) else $error("sample did not reach converter in five steps");

    property p_filterScale;
        @(posedge clk) disable iff (!rst_n)
        adv |=> (dacWord == clip($past(acc_q)));
    endproperty
    a_filterScale: assert property (p_filterScale) else $error("converter word not from filter");
endmodule : qdm_modulator

`default_nettype wire

/* File: tb/qdm_partner.sv */
// far side of the modulator: baseband sample source and converter sink
// assumes bench commands change just after the rising clock edge
`default_nettype none

module qdm_partner
    import qdm_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // bench commands
    input  wire logic                 srcEn,
    input  wire logic [QDM_SMP_W-1:0] srcI,
    input  wire logic [QDM_SMP_W-1:0] srcQ,
    input  wire logic                 stall,
    // sample side
    output logic                      sampleValid,
    output logic      [QDM_SMP_W-1:0] sampleI,
    output logic      [QDM_SMP_W-1:0] sampleQ,
    input  wire logic                 sampleReady,
    // converter side
    output logic                      dacReady,
    input  wire logic                 dacValid,
    // edges from first accepted pair to first word
    output logic      [9:0]           latency
);
    timeunit 1ns;
    timeprecision 100ps;

    // ********************************
    // source and sink
    // ********************************
    logic       started;
    logic       seen;
    logic [9:0] cnt;

    // offer held until taken; idle data toggles so stale values never match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sampleValid <= 1'b0;
            sampleI     <= '0;
            sampleQ     <= '0;
        end else if (!sampleValid || sampleReady) begin
            sampleValid <= srcEn;
            sampleI     <= srcEn ? srcI : ~sampleI;
            sampleQ     <= srcEn ? srcQ : ~sampleQ;
        end
    end

    // converter stalls on command
    assign dacReady = !stall;

    // latency from first accepted pair to first valid word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            started <= 1'b0;
            seen    <= 1'b0;
            cnt     <= '0;
            latency <= '0;
        end else begin
            if (sampleValid && sampleReady && !started) begin
                started <= 1'b1;
                cnt     <= '0;
            end else if (started) begin
                cnt <= cnt + 10'h001;
            end
            if (started && dacValid && dacReady && !seen) begin
                seen    <= 1'b1;
                latency <= cnt;
            end
        end
    end
endmodule : qdm_partner

`default_nettype wire

/* File: tb/test_quadrature_dds_modulator.sv */
// self-checking bench for the quadrature modulator back end
// assumes tuning word 0 after reset, so the carrier rests at phase 0
`default_nettype none

module test_quadrature_dds_modulator
    import qdm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ********************************
    // signals and instances
    // ********************************
    logic                 clk;
    logic                 rst_n;
    logic                 regWrite;
    logic [7:0]           regAddr;
    logic [7:0]           regWrData;
    logic [7:0]           regRdData;
    logic                 sampleValid;
    logic [QDM_SMP_W-1:0] sampleI;
    logic [QDM_SMP_W-1:0] sampleQ;
    logic                 sampleReady;
    logic                 dacReady;
    logic [QDM_DAC_W-1:0] dacWord;
    logic                 dacValid;
    logic                 srcEn;
    logic                 stall;
    logic [QDM_SMP_W-1:0] srcI;
    logic [QDM_SMP_W-1:0] srcQ;
    logic [9:0]           latency;
    logic [9:0]           held;
    logic [9:0]           w [12];
    int                   errors;
    int                   num_checks;
    logic [9:0]           vI [5] = '{10'h190, 10'h000, 10'h1FF, 10'h000, 10'h200};
    logic [9:0]           vQ [5] = '{10'h000, 10'h190, 10'h1FF, 10'h190, 10'h200};
    bit                   vInv [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};

    qdm_modulator i_dut (.clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .sampleValid(sampleValid), .sampleI(sampleI),
        .sampleQ(sampleQ), .sampleReady(sampleReady), .dacReady(dacReady), .dacWord(dacWord),
        .dacValid(dacValid));

    qdm_partner i_far (.clk(clk), .rst_n(rst_n), .srcEn(srcEn), .srcI(srcI), .srcQ(srcQ),
        .stall(stall), .sampleValid(sampleValid), .sampleI(sampleI), .sampleQ(sampleQ),
        .sampleReady(sampleReady), .dacReady(dacReady), .dacValid(dacValid), .latency(latency));

    // clock generation
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ********************************
    // tasks
    // ********************************
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite  <= 1'b0;
    endtask : regWr

    task automatic regRd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        @(posedge clk);
        @(negedge clk);
        chk({2'h0, regRdData}, {2'h0, e}, "register read");
    endtask : regRd

    // constant pair streamed long enough for the filter taps to settle
    task automatic stream(input logic [9:0] i, input logic [9:0] q);
        @(posedge clk);
        srcEn <= 1'b1;
        srcI  <= i;
        srcQ  <= q;
        repeat (14) @(posedge clk);
        @(negedge clk);
    endtask : stream

    task automatic grab();
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            w[k] = dacWord;
        end
    endtask : grab

    // steady word at phase 0: cos 510, sin 25, filter dc gain 16, shift 15
    function automatic logic [9:0] expDc(input int i, input int q, input bit inv);
        int s;
        s = (i * 510 + (inv ? -q : q) * 25) * 16;
        s = s >>> 15;
        s = (s > 511) ? 511 : ((s < -512) ? -512 : s);
        return s[9:0];
    endfunction : expDc

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // ********************************
    // main sequence
    // ********************************
    initial begin
        rst_n = 1'b0;
        regWrite = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        srcEn = 1'b0;
        srcI = 10'h000;
        srcQ = 10'h000;
        stall = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (19) @(posedge clk);
        @(negedge clk);
        chk({9'h0, sampleReady}, 10'h001, "ready in reset");
        chk({9'h0, dacValid}, 10'h000, "valid in reset");
        chk(dacWord, 10'h000, "word in reset");
        chk({2'h0, regRdData}, 10'h000, "read in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        $display("test reset done");

        // mixers, adder, inversion and filter at a resting carrier
        for (int k = 0; k < 5; k++) begin
            if (k == 3) regWr(QDM_ADDR_CTRL, 8'h01);
            stream(vI[k], vQ[k]);
            if (k == 0) chk(latency, 10'h005, "latency");
            chk({9'h0, dacValid}, 10'h001, "word valid");
            chk(dacWord, expDc($signed(vI[k]), $signed(vQ[k]), vInv[k]), "word");
        end
        regRd(QDM_ADDR_CTRL, 8'h01);
        regWr(QDM_ADDR_CTRL, 8'h00);
        $display("test datapath done");

        // stall: fifo fills and refuses, output holds, then drains empty
        @(posedge clk);
        stall <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        held = dacWord;
        for (int k = 0; k < 10 && sampleReady === 1'b1; k++) @(negedge clk);
        chk({9'h0, sampleReady}, 10'h000, "fifo full");
        // bound used up: mismatch already counted, go straight to the report
        if (sampleReady !== 1'b0) complete_run();
        chk(dacWord, held, "word held");
        @(posedge clk);
        srcEn <= 1'b0;
        stall <= 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        chk({9'h0, sampleReady}, 10'h001, "fifo empty");
        chk({9'h0, dacValid}, 10'h000, "drained");
        $display("test stall done");

        // tuning word bytes, pending flag, unmapped place
        regRd(QDM_ADDR_TW3, 8'h00);
        regWr(QDM_ADDR_TW0, 8'h00);
        regWr(QDM_ADDR_TW1, 8'h00);
        regWr(QDM_ADDR_TW2, 8'h00);
        regRd(QDM_ADDR_CTRL, 8'h02);
        regWr(QDM_ADDR_TW3, 8'h40);
        regRd(QDM_ADDR_CTRL, 8'h00);
        regRd(QDM_ADDR_TW3, 8'h40);
        regWr(8'h20, 8'hFF);
        regRd(8'h20, 8'h00);
        stream(10'h190, 10'h000);
        grab();
        chk(w[0], w[4], "quarter step period");
        chk(w[1], w[5], "quarter step period");
        chk({9'h0, w[0] !== w[2]}, 10'h001, "carrier moves");
        regWr(QDM_ADDR_TW3, 8'h20);
        repeat (10) @(posedge clk);
        grab();
        chk(w[0], w[4], "partial word unused");
        regWr(QDM_ADDR_TW0, 8'h00);
        regWr(QDM_ADDR_TW1, 8'h00);
        regWr(QDM_ADDR_TW2, 8'h00);
        repeat (10) @(posedge clk);
        grab();
        chk(w[0], w[8], "eighth step period");
        chk({9'h0, w[0] !== w[4]}, 10'h001, "new word applied");
        $display("test tuning done");
        complete_run();
    end
endmodule : test_quadrature_dds_modulator

`default_nettype wire
